/* bench/scc_osc_model.sv */
/*
 * External oscillator stand-in: a crystal or CMOS clock on the first
 * oscillator pin, swinging at a rate unrelated to the system clock.
 * Assumes the bench says when the resonator may swing, and the block's
 * drive enable says when it is powered.
 */
`timescale 1ns/1ps
module scc_osc_model #(
    parameter int HALF_NS = 53      // Half period, kept off the 10 ns grid
) (
    input  wire logic ext_en,       // Drive circuit enabled by the block
    input  wire logic run,          // Bench lets the resonator swing
    output logic      osc_pin_one   // Pin level seen by the block
);
    // Swing only while powered and allowed; a stopped part sits grounded
    always
    begin
        if (ext_en && run)
        begin
            #(HALF_NS) osc_pin_one = ~osc_pin_one;
        end
        else
        begin
            osc_pin_one = 1'b0;
            @(ext_en or run);
        end
    end
endmodule : scc_osc_model

/* bench/test_system_clock_source_control.sv */
/*
 * Self-checking bench for the clock source control block: APB register
 * access, internal tick rates, crystal bring-up, source switching,
 * missing clock detector and reset pin.
 * Assumes the oscillator model above and a 100 MHz clk_sys.
 */
`timescale 1ns/1ps
module test_system_clock_source_control;
    localparam int MCD_SIM = 300;                 // Short detector timeout
    logic                   clk_sys, rstn, rst_pin_n, osc_pin_one, run;
    logic                   psel, penable, pwrite, pready, pslverr, e, got;
    logic                   sys_tick, src_is_ext, mcd_reset;
    logic [11:0]            paddr;
    logic [31:0]            pwdata, prdata, q, d;
    scc_pkg::scc_osc_ctrl_s osc_ctrl;
    int                     mismatches, compares, seed, cyc, i, n;

    scc_clock_control #(.MCD_CYCLES(MCD_SIM), .SETTLE_EDGES(8)) dut (
        .clk_sys(clk_sys), .rstn(rstn), .rst_pin_n(rst_pin_n), .osc_pin_one(osc_pin_one),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_ctrl(osc_ctrl),
        .sys_tick(sys_tick), .src_is_ext(src_is_ext), .mcd_reset(mcd_reset));
    scc_osc_model osc (.ext_en(osc_ctrl.ext_en), .run(run), .osc_pin_one(osc_pin_one));

    // Free-running system clock
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Hang guard; the whole run needs well under a tenth of this
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            mismatches++;
            test_done();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd);
        @(posedge clk_sys);
        psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        // Only the hang guard ends a wait for the slave
        do
        begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    // Bounded wait for a level; n counts the edges waited
    task automatic wait_lvl(ref logic s, input logic lvl, input int lim);
        n = 0;
        while (s !== lvl && n < lim)
        begin
            @(posedge clk_sys);
            n++;
        end
        got = (s === lvl);
    endtask : wait_lvl

    // Step past the current pulse, then wait for the next one
    task automatic next_tick;
        @(posedge clk_sys);
        wait_lvl(sys_tick, 1'b1, 80);
    endtask : next_tick

    // Expected tick spacing in system cycles for a frequency code
    function automatic int exp_div(input logic [1:0] c);
        case (c)
            2'h0: return scc_pkg::INT_DIV_2M;
            2'h1: return scc_pkg::INT_DIV_4M;
            2'h2: return scc_pkg::INT_DIV_8M;
            default: return scc_pkg::INT_DIV_16M;
        endcase
    endfunction : exp_div

    task automatic test_done;
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
        begin
            $display("ALL TESTS PASSED");
        end
        else
        begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    // Main sequence
    initial
    begin
        {psel, penable, pwrite, run, rstn} = '0;
        paddr = '0; pwdata = '0; rst_pin_n = 1'b1;
        mismatches = 0; compares = 0; cyc = 0; seed = 32'h8108;
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (3) @(posedge clk_sys);       // Pin synchroniser settles first
        // Reset values, ready flag masked since it sets on its own
        apb(scc_pkg::ADDR_EXT_OSC, 1'b0, '0);
        check(q, 32'h30);
        apb(scc_pkg::ADDR_INT_OSC, 1'b0, '0);
        check(q & 32'hFFFF_FFEF, 32'h04);
        apb(12'h000, 1'b0, '0);
        check({e, q[30:0]}, 32'h8000_0000);
        $display("done: reset values");
        // Every frequency code; first gap skipped as it may be partial
        for (i = 0; i < 4; i++)
        begin
            apb(scc_pkg::ADDR_INT_OSC, 1'b1, 32'h04 | 32'(i));
            wait_lvl(sys_tick, 1'b1, 80);
            next_tick();
            next_tick();
            check(32'(n + 1), 32'(exp_div(i[1:0])));
            apb(scc_pkg::ADDR_INT_OSC, 1'b0, '0);
            check(q, 32'h14 | 32'(i));
            check(32'(osc_ctrl.int_freq), 32'(i));
        end
        $display("done: internal rates");
        // Disabled oscillator gives no edges; re-enabled it ticks at once
        apb(scc_pkg::ADDR_INT_OSC, 1'b1, 32'h03);
        repeat (3) @(posedge clk_sys);
        n = 0;
        repeat (100)
        begin
            @(posedge clk_sys);
            n += int'(sys_tick === 1'b1);
        end
        check({31'(n), osc_ctrl.int_en}, 32'h0);
        apb(scc_pkg::ADDR_INT_OSC, 1'b1, 32'h07);
        wait_lvl(sys_tick, 1'b1, 4);
        check(32'(got), 32'h1);
        $display("done: internal enable");
        // Random external settings, stored and passed to the pin driver
        repeat (8)
        begin
            d = $random(seed);
            apb(scc_pkg::ADDR_EXT_OSC, 1'b1, d);
            apb(scc_pkg::ADDR_EXT_OSC, 1'b0, '0);
            check(q & 32'h77, d & 32'h77);
            check({osc_ctrl.ext_mode, osc_ctrl.ext_freq, osc_ctrl.ext_en}, {d[6:4], d[2:0], d[6:5] != 2'h0});
        end
        $display("done: external fields");
        // Crystal bring-up as software should do it, then switch over and back
        apb(scc_pkg::ADDR_EXT_OSC, 1'b1, 32'h67);
        run <= 1'b1;
        apb(scc_pkg::ADDR_EXT_OSC, 1'b0, '0);
        check(32'(q[7]), 32'h0);
        repeat (200) @(posedge clk_sys);
        i = 0;
        do
        begin
            apb(scc_pkg::ADDR_EXT_OSC, 1'b0, '0);
            i++;
        end while (q[7] !== 1'b1 && i < 30);
        check(32'(q[7]), 32'h1);
        apb(scc_pkg::ADDR_INT_OSC, 1'b1, 32'h0F);
        wait_lvl(src_is_ext, 1'b1, 100);
        check(32'(got), 32'h1);
        apb(scc_pkg::ADDR_INT_OSC, 1'b1, 32'h07);
        wait_lvl(src_is_ext, 1'b0, 50);
        check({got, osc_ctrl.ext_en}, 2'b11);
        $display("done: crystal switch");
        // Detector armed on the external source, then the crystal stops
        apb(scc_pkg::ADDR_INT_OSC, 1'b1, 32'h8F);
        wait_lvl(src_is_ext, 1'b1, 100);
        check({got, osc_ctrl.mcd_en}, 2'b11);
        run <= 1'b0;
        wait_lvl(mcd_reset, 1'b1, MCD_SIM + 100);
        check({got, n >= MCD_SIM - 2}, 2'b11);
        repeat (2) @(posedge clk_sys);
        apb(scc_pkg::ADDR_INT_OSC, 1'b0, '0);
        check({src_is_ext, q[30:0] & 31'h7FFF_FFEF}, 32'h04);
        $display("done: missing clock");
        // Reset pin low stops both oscillators
        rst_pin_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check({osc_ctrl.int_en, osc_ctrl.ext_en}, 2'b00);
        rst_pin_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        $display("done: reset pin");
        test_done();
    end
endmodule : test_system_clock_source_control

/* hdl/scc_clock_control.sv */
/*
 * System clock source control: APB register file, internal oscillator tick
 * model, external pin clock detection, crystal valid detection, glitch-free
 * source switch and missing clock detector.
 * Assumes osc_pin_one and rst_pin_n are asynchronous to clk_sys, and that the
 * produced sys_tick stands for one system clock edge of the selected source.
 */
`timescale 1ns/1ps

module scc_clock_control #(
    parameter int MCD_CYCLES    = scc_pkg::MCD_TIMEOUT_CYC,
    parameter int SETTLE_EDGES  = scc_pkg::XTAL_SETTLE_EDGES
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rstn,
    input  wire logic                  rst_pin_n,
    input  wire logic                  osc_pin_one,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    output scc_pkg::scc_osc_ctrl_s     osc_ctrl,
    output logic                       sys_tick,
    output logic                       src_is_ext,
    output logic                       mcd_reset
);

    localparam int MCW = $clog2(MCD_CYCLES + 1);
    localparam int XEW = $clog2(SETTLE_EDGES + 1);
    localparam int XGW = $clog2(scc_pkg::XTAL_GAP_CYC + 1);
    localparam int INT_WAIT_MAX = 50;

    // Switch states, one-hot
    typedef enum logic [3:0] {
        ST_INT    = 4'h1,
        ST_TO_EXT = 4'h2,
        ST_EXT    = 4'h4,
        ST_TO_INT = 4'h8
    } scc_sw_e;

    scc_sw_e      sw_reg;            // Switch state
    logic [1:0]   pin_rst_sync;      // Reset pin synchroniser
    logic [2:0]   osc_sync;          // Osc pin synchroniser plus edge stage
    logic         pin_ok;            // Reset pin released, synchronised
    logic         soft_clr;          // Any in-block reset event
    logic         mcd_en_reg;        // Detector armed
    logic         sel_reg;           // Source select
    logic         int_en_reg;        // Internal oscillator enable
    logic [1:0]   int_freq_reg;      // Internal frequency code
    logic [2:0]   ext_mode_reg;      // External mode code
    logic [2:0]   ext_freq_reg;      // External frequency range
    logic         int_ready_reg;     // Internal at speed
    logic         xtal_valid_reg;    // Crystal stable
    logic [5:0]   int_cnt_reg;       // Internal tick divider
    logic [5:0]   int_div;           // Divider limit for code
    logic         int_tick;          // Internal clock edge
    logic         ext_edge;          // Raw external rising edge
    logic         ext_half_reg;      // Divide-by-2 phase
    logic         ext_div2;          // Mode halves external clock
    logic         ext_tick;          // External clock edge after divider
    logic         ext_on;            // External driver enabled
    logic         xtal_mode;         // Crystal mode selected
    logic [XEW-1:0] xtal_edges_reg;  // Good crystal edges seen
    logic [XGW-1:0] xtal_gap_reg;    // Cycles since last edge
    logic [MCW-1:0] mcd_cnt_reg;     // Cycles since last system tick
    logic         wr_int;            // Write to internal register
    logic         wr_ext;            // Write to external register
    logic         addr_hit;          // Mapped address

    // Reset pin and oscillator pin synchronisers
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            pin_rst_sync <= 2'h0;
            osc_sync     <= 3'h0;
        end
        else
        begin
            pin_rst_sync <= {pin_rst_sync[0], rst_pin_n};
            osc_sync     <= {osc_sync[1:0], osc_pin_one};
        end
    end

    assign pin_ok   = pin_rst_sync[1];
    assign soft_clr = !pin_ok || mcd_reset;

    // APB decode; zero wait states, error on unmapped words
    assign addr_hit = (paddr == scc_pkg::ADDR_EXT_OSC) || (paddr == scc_pkg::ADDR_INT_OSC);
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !addr_hit;
    assign wr_int   = psel && penable && pwrite && (paddr == scc_pkg::ADDR_INT_OSC);
    assign wr_ext   = psel && penable && pwrite && (paddr == scc_pkg::ADDR_EXT_OSC);

    // Internal control register; every in-block reset restores reset value
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            mcd_en_reg   <= scc_pkg::INT_OSC_RESET[scc_pkg::INT_MCD_EN_BIT];
            sel_reg      <= scc_pkg::INT_OSC_RESET[scc_pkg::INT_SEL_BIT];
            int_en_reg   <= scc_pkg::INT_OSC_RESET[scc_pkg::INT_EN_BIT];
            int_freq_reg <= scc_pkg::INT_OSC_RESET[scc_pkg::INT_FREQ_LSB +: 2];
        end
        else if (soft_clr)
        begin
            // Select back to internal after any reset
            mcd_en_reg   <= scc_pkg::INT_OSC_RESET[scc_pkg::INT_MCD_EN_BIT];
            sel_reg      <= scc_pkg::INT_OSC_RESET[scc_pkg::INT_SEL_BIT];
            int_en_reg   <= scc_pkg::INT_OSC_RESET[scc_pkg::INT_EN_BIT];
            int_freq_reg <= scc_pkg::INT_OSC_RESET[scc_pkg::INT_FREQ_LSB +: 2];
        end
        else if (wr_int)
        begin
            mcd_en_reg   <= pwdata[scc_pkg::INT_MCD_EN_BIT];
            sel_reg      <= pwdata[scc_pkg::INT_SEL_BIT];
            int_en_reg   <= pwdata[scc_pkg::INT_EN_BIT];
            int_freq_reg <= pwdata[scc_pkg::INT_FREQ_LSB +: 2];
        end
    end

    // External control register
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            ext_mode_reg <= scc_pkg::EXT_OSC_RESET[scc_pkg::EXT_MODE_LSB +: 3];
            ext_freq_reg <= scc_pkg::EXT_OSC_RESET[scc_pkg::EXT_FREQ_LSB +: 3];
        end
        else if (soft_clr)
        begin
            ext_mode_reg <= scc_pkg::EXT_OSC_RESET[scc_pkg::EXT_MODE_LSB +: 3];
            ext_freq_reg <= scc_pkg::EXT_OSC_RESET[scc_pkg::EXT_FREQ_LSB +: 3];
        end
        else if (wr_ext)
        begin
            ext_mode_reg <= pwdata[scc_pkg::EXT_MODE_LSB +: 3];
            ext_freq_reg <= pwdata[scc_pkg::EXT_FREQ_LSB +: 3];
        end
    end

    // Read data captured in setup phase, stable through access phase
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable)
        begin
            if (paddr == scc_pkg::ADDR_INT_OSC)
                prdata <= {24'h000000, mcd_en_reg, 2'h0, int_ready_reg, sel_reg, int_en_reg, int_freq_reg};
            else if (paddr == scc_pkg::ADDR_EXT_OSC)
                // Reserved bit 3 reads zero; valid flag is read-only
                prdata <= {24'h000000, xtal_valid_reg, ext_mode_reg, 1'b0, ext_freq_reg};
            else
                prdata <= 32'h0000_0000;
        end
    end

    // Oscillator controls; pin reset forces both off
    assign ext_on    = (ext_mode_reg[2:1] != scc_pkg::MODE_OFF_HI) && pin_ok;
    assign xtal_mode = (ext_mode_reg[2:1] == scc_pkg::MODE_XTAL_HI);
    assign ext_div2  = ext_mode_reg[0] && (ext_mode_reg[2:1] != scc_pkg::MODE_OFF_HI);

    always_comb
    begin
        osc_ctrl.int_en   = int_en_reg && pin_ok;
        osc_ctrl.int_freq = int_freq_reg;
        osc_ctrl.ext_en   = ext_on;
        osc_ctrl.ext_mode = ext_mode_reg;
        osc_ctrl.ext_freq = ext_freq_reg;
        osc_ctrl.mcd_en   = mcd_en_reg;
    end

    // Divider limit per frequency code
    always_comb
    begin
        unique case (int_freq_reg)
            2'h0: int_div = 6'(scc_pkg::INT_DIV_2M);
            2'h1: int_div = 6'(scc_pkg::INT_DIV_4M);
            2'h2: int_div = 6'(scc_pkg::INT_DIV_8M);
            2'h3: int_div = 6'(scc_pkg::INT_DIV_16M);
        endcase
    end

    // Internal oscillator model; parked at top while off, so the first enabled cycle ticks
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            int_cnt_reg <= 6'h3F;
        else if (!osc_ctrl.int_en)
            int_cnt_reg <= 6'h3F;
        else if (int_tick)
            int_cnt_reg <= 6'h00;
        else
            int_cnt_reg <= int_cnt_reg + 6'h01;
    end

    // Tick spacing equals the divider limit; no start-up wait
    assign int_tick = osc_ctrl.int_en && (int_cnt_reg >= int_div - 6'h01);

    // At-speed flag; lost on disable or on a written frequency change, regained at next edge
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            int_ready_reg <= 1'b0;
        else if (!osc_ctrl.int_en || (wr_int && pwdata[scc_pkg::INT_FREQ_LSB +: 2] != int_freq_reg))
            int_ready_reg <= 1'b0;
        else if (int_tick)
            int_ready_reg <= 1'b1;
    end

    // External edge, optional halving
    assign ext_edge = ext_on && osc_sync[1] && !osc_sync[2];

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            ext_half_reg <= 1'b0;
        else if (!ext_on)
            ext_half_reg <= 1'b0;
        else if (ext_edge)
            ext_half_reg <= !ext_half_reg;
    end

    assign ext_tick = ext_edge && (!ext_div2 || ext_half_reg);

    // Crystal detect: enough edges with no long gap; only in crystal mode
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            xtal_gap_reg   <= '0;
            xtal_edges_reg <= '0;
            xtal_valid_reg <= 1'b0;
        end
        else if (!xtal_mode || !ext_on)
        begin
            xtal_gap_reg   <= '0;
            xtal_edges_reg <= '0;
            xtal_valid_reg <= 1'b0;
        end
        else if (ext_edge)
        begin
            xtal_gap_reg <= '0;
            if (xtal_edges_reg == XEW'(SETTLE_EDGES))
                xtal_valid_reg <= 1'b1;
            else
                xtal_edges_reg <= xtal_edges_reg + XEW'(1);
        end
        else if (xtal_gap_reg == XGW'(scc_pkg::XTAL_GAP_CYC))
        begin
            // Oscillation stalled; start settling over
            xtal_edges_reg <= '0;
            xtal_valid_reg <= 1'b0;
        end
        else
            xtal_gap_reg <= xtal_gap_reg + XGW'(1);
    end

    // Source switch: old source is cut only between edges, new one starts on its own edge
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            sw_reg <= ST_INT;
        else if (soft_clr)
            sw_reg <= ST_INT;
        else
        begin
            unique case (sw_reg)
                ST_INT:
                    if (sel_reg && ext_on)
                        sw_reg <= ST_TO_EXT;
                ST_TO_EXT:
                    if (!sel_reg || !ext_on)
                        sw_reg <= ST_TO_INT;
                    else if (ext_tick)
                        sw_reg <= ST_EXT;
                ST_EXT:
                    if (!sel_reg || !ext_on)
                        sw_reg <= ST_TO_INT;
                ST_TO_INT:
                    if (int_tick)
                        sw_reg <= ST_INT;
            endcase
        end
    end

    // Registered system edge and source indication
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            sys_tick   <= 1'b0;
            src_is_ext <= 1'b0;
        end
        else
        begin
            sys_tick   <= ((sw_reg == ST_INT || sw_reg == ST_TO_INT) && int_tick && !soft_clr) ||
                          ((sw_reg == ST_EXT || sw_reg == ST_TO_EXT) && ext_tick && sel_reg && !soft_clr);
            src_is_ext <= (sw_reg == ST_EXT) && !soft_clr;
        end
    end

    // Missing clock detector; counts cycles since last system edge
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            mcd_cnt_reg <= '0;
            mcd_reset   <= 1'b0;
        end
        else if (!mcd_en_reg || sys_tick || mcd_reset)
        begin
            mcd_cnt_reg <= '0;
            mcd_reset   <= 1'b0;
        end
        else if (mcd_cnt_reg == MCW'(MCD_CYCLES - 1))
        begin
            mcd_cnt_reg <= '0;
            mcd_reset   <= 1'b1;
        end
        else
            mcd_cnt_reg <= mcd_cnt_reg + MCW'(1);
    end

    // Handover step to the external source, and an internal register write
    sequence s_want_ext;
        sw_reg == ST_TO_EXT && ext_tick && sel_reg && ext_on && !soft_clr;
    endsequence

    sequence s_int_write;
        wr_int && !soft_clr;
    endsequence

    a_reset_internal: assert property (@(posedge clk_sys) disable iff (!rstn)
        soft_clr |=> !sel_reg && sw_reg == ST_INT && !src_is_ext)
        else $error("select not back to internal after reset");

    a_int_starts_fast: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(osc_ctrl.int_en) |-> ##[0:INT_WAIT_MAX] int_tick)
        else $error("internal oscillator slow to start");

    a_int_enable_write: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_int_write ##1 pin_ok |-> osc_ctrl.int_en == $past(pwdata[scc_pkg::INT_EN_BIT]))
        else $error("internal enable does not follow write");

    a_freq_code_write: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_int_write |=> osc_ctrl.int_freq == $past(pwdata[1:0]))
        else $error("frequency code does not follow write");

    a_pin_low_off: assert property (@(posedge clk_sys) disable iff (!rstn)
        !pin_ok |-> !osc_ctrl.int_en && !osc_ctrl.ext_en)
        else $error("oscillator enabled while reset pin low");

    a_switch_to_ext: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_want_ext |=> sw_reg == ST_EXT ##1 src_is_ext)
        else $error("handover to external source missed");

    a_ext_keeps_run: assert property (@(posedge clk_sys) disable iff (!rstn)
        ($fell(sel_reg) && $stable(ext_mode_reg) && pin_ok && $past(pin_ok)) |-> $stable(osc_ctrl.ext_en))
        else $error("external oscillator stopped on switch back");

    a_xtal_flag_mode: assert property (@(posedge clk_sys) disable iff (!rstn)
        !xtal_mode |=> !xtal_valid_reg)
        else $error("crystal valid outside crystal mode");

    a_mcd_disarmed: assert property (@(posedge clk_sys) disable iff (!rstn)
        !mcd_en_reg |=> !mcd_reset)
        else $error("detector fired while disabled");

    a_mcd_timeout: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(mcd_reset) |-> $past(mcd_cnt_reg) == MCW'(MCD_CYCLES - 1) && !$past(sys_tick))
        else $error("detector fired at wrong count");

    a_no_short_edge: assert property (@(posedge clk_sys) disable iff (!rstn)
        (sw_reg == ST_TO_EXT && !ext_tick) |=> !sys_tick)
        else $error("system edge during handover");

endmodule : scc_clock_control

/* hdl/scc_pkg.sv */
/*
 * Package for the system clock source control block: register indices,
 * byte addresses, field positions, reset values, mode codes, timing figures
 * and the packed struct that carries oscillator controls to the analog side.
 * Assumes a 100 MHz system clock and a 32-bit APB with 12-bit byte addresses.
 */
package scc_pkg;

    // Register indices as printed; byte address is four times the index
    localparam logic [9:0]  IDX_EXT_OSC  = 10'h0B1;
    localparam logic [9:0]  IDX_INT_OSC  = 10'h0B2;
    localparam logic [11:0] ADDR_EXT_OSC = {IDX_EXT_OSC, 2'b00};
    localparam logic [11:0] ADDR_INT_OSC = {IDX_INT_OSC, 2'b00};

    // Reset values
    localparam logic [7:0] EXT_OSC_RESET = 8'h30;
    localparam logic [7:0] INT_OSC_RESET = 8'h04;

    // Internal oscillator control fields
    localparam int INT_MCD_EN_BIT = 7;
    localparam int INT_READY_BIT  = 4;
    localparam int INT_SEL_BIT    = 3;
    localparam int INT_EN_BIT     = 2;
    localparam int INT_FREQ_LSB   = 0;

    // External oscillator control fields
    localparam int EXT_VALID_BIT = 7;
    localparam int EXT_MODE_LSB  = 4;
    localparam int EXT_FREQ_LSB  = 0;

    // External mode codes
    localparam logic [2:0] MODE_CMOS     = 3'h2;
    localparam logic [2:0] MODE_CMOS_DV2 = 3'h3;
    localparam logic [1:0] MODE_RC_HI    = 2'h2;
    localparam logic [1:0] MODE_XTAL_HI  = 2'h3;
    localparam logic [1:0] MODE_OFF_HI   = 2'h0;

    // Timing figures
    localparam int CLK_PERIOD_NS  = 10;
    localparam int MCD_TIMEOUT_US = 100;
    localparam int MCD_TIMEOUT_CYC = (MCD_TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int XTAL_GAP_NS    = 2000;
    localparam int XTAL_GAP_CYC   = XTAL_GAP_NS / CLK_PERIOD_NS;
    localparam int XTAL_SETTLE_EDGES = 1024;

    // Internal oscillator periods in ns, nominal 2/4/8/16 MHz
    localparam int INT_PER_2M_NS  = 500;
    localparam int INT_PER_4M_NS  = 250;
    localparam int INT_PER_8M_NS  = 125;
    localparam int INT_PER_16M_NS = 62;
    localparam int INT_DIV_2M  = INT_PER_2M_NS / CLK_PERIOD_NS;
    localparam int INT_DIV_4M  = INT_PER_4M_NS / CLK_PERIOD_NS;
    localparam int INT_DIV_8M  = INT_PER_8M_NS / CLK_PERIOD_NS;
    localparam int INT_DIV_16M = INT_PER_16M_NS / CLK_PERIOD_NS;

    // Controls toward the oscillator circuits
    typedef struct packed {
        logic       int_en;
        logic [1:0] int_freq;
        logic       ext_en;
        logic [2:0] ext_mode;
        logic [2:0] ext_freq;
        logic       mcd_en;
    } scc_osc_ctrl_s;

endpackage : scc_pkg
